// >>> shared/wpc_defines.svh
// Offsets, field positions, reset values and timing counts for write permission control.
`ifndef WPC_DEFINES_SVH
`define WPC_DEFINES_SVH
`define WPC_CLK_MHZ          250
`define WPC_STATUS_ADDR      8'hff
`define WPC_SLAVE_RD_BYTE    8'ha5
`define WPC_SLAVE_WR_BYTE    8'ha4
`define WPC_WEL_BIT          1
`define WPC_REG_WRITE_ENABLE_LATCH_BIT         2
`define WPC_LOCK_LO_BIT      3
`define WPC_LOCK_HI_BIT      4
`define WPC_SET_WEL_VAL      8'h02
`define WPC_CLR_WEL_VAL      8'h00
`define WPC_SET_REG_WRITE_ENABLE_LATCH_VAL     8'h06
`define WPC_LOCK_RESET       2'h0
`define WPC_QTR_BASE         8'hc0
`define WPC_HALF_BASE        8'h80
`define WPC_MISMATCH_CLKS    9
`define WPC_READ_IDLE_NS     200
`define WPC_READ_IDLE_CYC    ((`WPC_READ_IDLE_NS * `WPC_CLK_MHZ) / 1000)
`define WPC_NV_WC_MS         10
`define WPC_NV_WC_CYC        (`WPC_NV_WC_MS * `WPC_CLK_MHZ * 1000)
`endif

// >>> shared/wpc_pkg.sv
// Types shared by the write permission control block.
package wpc_pkg;
  typedef enum logic [1:0] {
    WPC_TGT_POT_VOL = 2'b00,
    WPC_TGT_POT_NV  = 2'b01,
    WPC_TGT_EEPROM  = 2'b10,
    WPC_TGT_STATUS  = 2'b11
  } wpc_target_e;

  typedef struct packed {
    logic        valid;
    wpc_target_e target;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic        byteCountOk;
    logic        bitSeqOk;
  } wpc_wreq_s;

  typedef enum logic [1:0] {
    WPC_ST_STANDBY  = 2'b00,
    WPC_ST_ACTIVE   = 2'b01,
    WPC_ST_SETTLE   = 2'b10,
    WPC_ST_NVCYCLE  = 2'b11
  } wpc_power_e;
endpackage

// >>> hdl/wpc_sync3.sv
// Three-flop input synchroniser whose output changes once stages two and three agree.
`timescale 1ns/1ps
module wpc_sync3 (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Raw level and its filtered copy.
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic [2:0] stage_q;

  // Stage one is read only by stage two to keep metastability contained.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], asyncIn};
    end
  end

  // Output follows only when the two settled stages agree.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncOut <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      syncOut <= stage_q[2];
    end
  end
endmodule

// >>> hdl/write_permission_control.sv
// Write permission decisions, status byte reads and standby timing for the two-wire device.
// How it works
// - Status read: address byte then FFh.
// - One status byte per read, then idle.
// - Status reads never disturb latch sequence.
// - Reserved upper three and lowest bits read zero.
// - All writes but a status 02h refused without write-enable latch.
// - Status writes other than 00h, 02h, 06h also need register-write latch.
// - Locks guard EEPROM regions and potentiometers.
// - Protect pin high blocks nonvolatile writes.
// - Protect high: only unlocked volatile pot writes.
// - Protect low: locks refuse pots, limit EEPROM.
// - Nonvolatile cycle needs proper counts at STOP.
// - Mismatched select returns standby after nine clocks.
// - STOP after read: standby after 200 ns.
// - STOP after nonvolatile write: stay active full cycle.
// - Write-enable latch set by 02h, cleared by 00h.
// - Value 06h sets both latches, needs prior latch.
// - Lock codes select none, quarter, half, all.
// - Refused write withholds data byte acknowledge.
`timescale 1ns/1ps
`include "wpc_defines.svh"
module write_permission_control
  import wpc_pkg::*;
#(
  parameter int unsigned NV_WC_CYC = `WPC_NV_WC_CYC
) (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Write-protect pin, asynchronous.
  input  wire logic       writeProtectPin,
  // Bus events from the serial front end, same clock.
  input  wire logic       startSeen,
  input  wire logic       stopSeen,
  input  wire logic       sclRise,
  input  wire logic       selectMismatch,
  input  wire logic       statusReadReq,
  input  wire logic [7:0] readAddr,
  input  wire wpc_wreq_s  writeReq,
  // Decisions and status.
  output logic            writeAck,
  output logic            writeNack,
  output logic [7:0]      statusByte,
  output logic            statusValid,
  output logic            serialIdle,
  output logic            nvWriteStart,
  output logic            deviceActive,
  output logic [1:0]      lockBits
);
  localparam logic [31:0] READ_IDLE_CYC = `WPC_READ_IDLE_CYC;
  localparam logic [31:0] NV_CYC        = NV_WC_CYC;
  localparam logic [3:0]  MISMATCH_CLKS = 4'(`WPC_MISMATCH_CLKS);

  logic       wpSync;
  logic       wel_q;
  logic       reg_write_enable_latch_q;
  logic [1:0] lock_q;
  logic [1:0] lockPend_q;
  logic       nvPend_q;
  logic       nvOk_q;
  logic       writeOk;
  logic       regionLocked;
  logic       lockAny;
  logic [7:0] csr;
  wpc_power_e pwr_q;
  logic [31:0] timer_q;
  logic [3:0]  clkCnt_q;

  // Protect pin crosses in through three flops.
  wpc_sync3 u_wp_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .asyncIn  (writeProtectPin),
    .syncOut  (wpSync)
  );

  // Region decode from the lock code.
  always_comb begin
    lockAny = |lock_q;
    case (lock_q)
      2'b00:   regionLocked = 1'b0;
      2'b01:   regionLocked = (writeReq.addr >= `WPC_QTR_BASE);
      2'b10:   regionLocked = (writeReq.addr >= `WPC_HALF_BASE);
      default: regionLocked = 1'b1;
    endcase
  end

  // Permission matrix, write-enable latch first, then protect pin and locks per target.
  always_comb begin
    writeOk = 1'b0;
    if (wel_q) begin
      case (writeReq.target)
        WPC_TGT_POT_VOL: writeOk = !lockAny;
        WPC_TGT_POT_NV:  writeOk = !lockAny && !wpSync;
        WPC_TGT_EEPROM:  writeOk = !regionLocked && !wpSync;
        // Latch-only writes need no register latch; any other byte does.
        WPC_TGT_STATUS:  writeOk = !wpSync &&
          ((writeReq.data == `WPC_CLR_WEL_VAL) || (writeReq.data == `WPC_SET_WEL_VAL) ||
           (writeReq.data == `WPC_SET_REG_WRITE_ENABLE_LATCH_VAL) || reg_write_enable_latch_q);
        default:         writeOk = 1'b0;
      endcase
    end else begin
      // The first 02h is the only write allowed before the latch is set.
      writeOk = (writeReq.target == WPC_TGT_STATUS) && !wpSync &&
                (writeReq.data == `WPC_SET_WEL_VAL);
    end
  end

  // Acknowledge decisions are combinational handshakes.
  assign writeAck  = writeReq.valid && writeOk;
  assign writeNack = writeReq.valid && !writeOk;

  // Status byte with reserved bits forced low.
  always_comb begin
    csr = 8'h00;
    csr[`WPC_WEL_BIT]     = wel_q;
    csr[`WPC_REG_WRITE_ENABLE_LATCH_BIT]    = reg_write_enable_latch_q;
    csr[`WPC_LOCK_LO_BIT] = lock_q[0];
    csr[`WPC_LOCK_HI_BIT] = lock_q[1];
  end

  // Latch updates; power-up clears the volatile latches.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wel_q  <= 1'b0;
      reg_write_enable_latch_q <= 1'b0;
    end else if (writeAck && writeReq.target == WPC_TGT_STATUS) begin
      if (writeReq.data == `WPC_CLR_WEL_VAL) begin
        wel_q  <= 1'b0;
        reg_write_enable_latch_q <= 1'b0;
      end else if (writeReq.data == `WPC_SET_WEL_VAL && !reg_write_enable_latch_q) begin
        wel_q <= 1'b1;
      end else if (writeReq.data == `WPC_SET_REG_WRITE_ENABLE_LATCH_VAL) begin
        wel_q  <= 1'b1;
        reg_write_enable_latch_q <= wel_q;
      end else begin
        wel_q  <= writeReq.data[`WPC_WEL_BIT];
        reg_write_enable_latch_q <= 1'b0; // A lock write consumes the register latch.
      end
    end else if (writeNack && writeReq.target == WPC_TGT_EEPROM && regionLocked) begin
      reg_write_enable_latch_q <= 1'b0; // Writing into a locked region drops the register latch.
    end
  end

  // Pending nonvolatile store, committed only at a well-formed STOP.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nvPend_q   <= 1'b0;
      nvOk_q     <= 1'b0;
      lockPend_q <= `WPC_LOCK_RESET;
    end else if (stopSeen || startSeen) begin
      nvPend_q <= 1'b0;
    end else if (writeAck && writeReq.target != WPC_TGT_POT_VOL) begin
      // With the register latch set, 02h is a lock write of 00 and clears the locks.
      nvPend_q <= (writeReq.target != WPC_TGT_STATUS) || (reg_write_enable_latch_q &&
                  writeReq.data != `WPC_SET_REG_WRITE_ENABLE_LATCH_VAL && writeReq.data != `WPC_CLR_WEL_VAL);
      nvOk_q   <= writeReq.byteCountOk && writeReq.bitSeqOk;
      if (writeReq.target == WPC_TGT_STATUS) begin
        lockPend_q <= {writeReq.data[`WPC_LOCK_HI_BIT], writeReq.data[`WPC_LOCK_LO_BIT]};
      end else begin
        // A memory or pot store must not launch a stale lock code left pending.
        lockPend_q <= lock_q;
      end
    end
  end

  assign nvWriteStart = stopSeen && nvPend_q && nvOk_q;

  // Lock bits take their stored value when the cycle launches.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_q <= `WPC_LOCK_RESET;
    end else if (nvWriteStart && lockPend_q != lock_q && !wpSync) begin
      lock_q <= lockPend_q;
    end
  end

  // Status reads answer on the next clock and never touch the latches.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      statusByte  <= 8'h00;
      statusValid <= 1'b0;
      serialIdle  <= 1'b1;
    end else begin
      statusValid <= statusReadReq && (readAddr == `WPC_STATUS_ADDR);
      if (statusReadReq && readAddr == `WPC_STATUS_ADDR) begin
        statusByte <= csr;
        serialIdle <= 1'b1;
      end else if (startSeen) begin
        serialIdle <= 1'b0;
      end else if (stopSeen) begin
        serialIdle <= 1'b1;
      end
    end
  end

  // Active and standby timing around START and STOP.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_q    <= WPC_ST_STANDBY;
      timer_q  <= 32'h0;
      clkCnt_q <= 4'h0;
    end else begin
      case (pwr_q)
        WPC_ST_STANDBY: begin
          if (startSeen) begin
            pwr_q    <= WPC_ST_ACTIVE;
            clkCnt_q <= 4'h0;
          end
        end
        WPC_ST_ACTIVE: begin
          if (nvWriteStart) begin
            pwr_q   <= WPC_ST_NVCYCLE;
            timer_q <= NV_CYC - 32'h1;
          end else if (stopSeen) begin
            pwr_q   <= WPC_ST_SETTLE;
            timer_q <= READ_IDLE_CYC - 32'h1;
          end else if (selectMismatch && sclRise) begin
            if (clkCnt_q == MISMATCH_CLKS - 4'h1) begin
              pwr_q <= WPC_ST_STANDBY;
            end else begin
              clkCnt_q <= clkCnt_q + 4'h1;
            end
          end
        end
        WPC_ST_SETTLE, WPC_ST_NVCYCLE: begin
          if (startSeen && pwr_q == WPC_ST_SETTLE) begin
            pwr_q    <= WPC_ST_ACTIVE;
            clkCnt_q <= 4'h0;
          end else if (timer_q == 32'h0) begin
            pwr_q <= WPC_ST_STANDBY;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        default: pwr_q <= WPC_ST_STANDBY;
      endcase
    end
  end

  assign deviceActive = (pwr_q != WPC_ST_STANDBY);
  assign lockBits     = lock_q;
endmodule

// >>> verif/wpc_monitor.sv
// Port assertions for write permission control.
`timescale 1ns/1ps
// ====
// Checker
module wpc_monitor
  import wpc_pkg::*;
(
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       reset_n,
  // Inputs.
  input wire logic       writeProtectPin,
  input wire logic       stopSeen,
  input wire logic       statusReadReq,
  input wire logic [7:0] readAddr,
  input wire wpc_wreq_s  writeReq,
  // Outputs.
  input wire logic       writeAck,
  input wire logic       writeNack,
  input wire logic [7:0] statusByte,
  input wire logic       statusValid,
  input wire logic       serialIdle,
  input wire logic       nvWriteStart,
  input wire logic       deviceActive,
  input wire logic [1:0] lockBits
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] wpCnt_q;
  // Counts protect-high cycles so the synchroniser delay is covered.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) wpCnt_q <= 3'h0;
    else if (!writeProtectPin) wpCnt_q <= 3'h0;
    else if (wpCnt_q != 3'h7) wpCnt_q <= wpCnt_q + 3'h1;
  end
  sequence sWpHeld; wpCnt_q == 3'h7; endsequence
  sequence sNvReq; writeReq.valid && writeReq.target != WPC_TGT_POT_VOL; endsequence
  a_reserved_bits_zero: assert property (statusValid |-> statusByte[7:5] == 3'h0 && !statusByte[0])
    else $error("reserved status bits not zero");
  a_one_decision: assert property (writeReq.valid |-> writeAck ^ writeNack)
    else $error("write has no single decision");
  a_status_answer: assert property (statusReadReq && readAddr == 8'hff |=> statusValid)
    else $error("status read not answered");
  a_idle_after_read: assert property (statusValid |-> ##[0:1] serialIdle)
    else $error("not idle after status byte");
  a_pot_lock_refused: assert property (writeReq.valid && !writeReq.target[1]
    && lockBits != 2'h0 |-> writeNack)
    else $error("locked pot write taken");
  a_wp_nv_refused: assert property (sWpHeld ##0 sNvReq |-> writeNack)
    else $error("protected write taken");
  a_full_lock: assert property (writeReq.valid && writeReq.target == WPC_TGT_EEPROM
    && lockBits == 2'h3 |-> writeNack)
    else $error("fully locked array written");
  a_launch_on_stop: assert property (nvWriteStart |-> stopSeen)
    else $error("nv launch without stop");
  a_nv_held_active: assert property (nvWriteStart |=> deviceActive [*8])
    else $error("standby during nv cycle");
endmodule
bind write_permission_control wpc_monitor u_wpc_monitor (.*);

// >>> verif/wpc_master_model.sv
// Behavioural two-wire master handing bus events to the block.
`timescale 1ns/1ps
// ====
// Master model
module wpc_master_model
  import wpc_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Bus events.
  output logic       startSeen,
  output logic       stopSeen,
  output logic       sclRise,
  output logic       selectMismatch,
  output logic       statusReadReq,
  output logic [7:0] readAddr,
  output wpc_wreq_s  writeReq
);
  // Idle bus; released write data flips so stale values are never trusted.
  initial begin
    {selectMismatch, sclRise, stopSeen, startSeen, statusReadReq} = 5'h0;
    readAddr = 8'h00;
    writeReq = '0;
  end
  // One write byte with the count and sequence flags given by ok, held for one edge.
  task automatic send(input wpc_target_e t, input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] ok);
    @(posedge core_clk) #1;
    writeReq = '{1'b1, t, a, d, ok[1], ok[0]};
    @(posedge core_clk) #1;
    writeReq.valid = 1'b0;
    writeReq.data = ~d;
  endtask
  // Status read at the given address; one byte only.
  task automatic rdStatus(input logic [7:0] a);
    @(posedge core_clk) #1;
    statusReadReq = 1'b1;
    readAddr = a;
    @(posedge core_clk) #1;
    statusReadReq = 1'b0;
    readAddr = 8'h00;
  endtask
  // Mismatch level plus one-cycle scl, stop and start pulses.
  task automatic ev(input logic [3:0] m);
    @(posedge core_clk) #1;
    {selectMismatch, sclRise, stopSeen, startSeen} = m;
    @(posedge core_clk) #1;
    {sclRise, stopSeen, startSeen} = 3'h0;
  endtask
endmodule

// >>> verif/write_permission_control_tb_top.sv
// Self-checking bench for write permission control.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin nMismatch++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
// ====
// Bench
module write_permission_control_tb_top;
  import wpc_pkg::*;
  logic core_clk, reset_n, writeProtectPin, startSeen, stopSeen, sclRise;
  logic selectMismatch, statusReadReq, writeAck, writeNack, statusValid;
  logic serialIdle, nvWriteStart, deviceActive, nvSeen;
  logic [7:0] readAddr, statusByte, base, expStat;
  logic [1:0] seqOk = 2'h3;
  logic [1:0] lockBits;
  wpc_wreq_s writeReq;
  logic qAck[$];
  logic [7:0] qStat[$];
  int nMismatch = 0, checksDone = 0, cyc = 0;
  write_permission_control #(.NV_WC_CYC(100)) u_write_permission_control (.*);
  wpc_master_model u_wpc_master_model (.*);
  // Clock at 250 MHz.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input wpc_target_e t, input logic [7:0] a, d, input logic e);
    qAck.push_back(e);
    u_wpc_master_model.send(t, a, d, seqOk);
  endtask
  task automatic rd(input logic [7:0] e);
    qStat.push_back(e);
    u_wpc_master_model.rdStatus(8'hff);
  endtask
  // Scoreboard takes the oldest note when a result appears; also cuts hangs.
  always @(posedge core_clk) begin
    cyc++;
    if (stopSeen) nvSeen <= nvWriteStart;
    if (writeReq.valid && qAck.size() > 0) `CHK("decision", {qAck[0], ~qAck[0]}, {writeAck, writeNack})
    if (writeReq.valid) void'(qAck.pop_front());
    if (statusValid && qStat.size() > 0) begin
      expStat = qStat.pop_front();
      `CHK("status", expStat, statusByte)
    end
    if (cyc == 3000) begin
      nMismatch++;
      completeRun();
    end
  end
  // Main sequence; ends the run unless the 3000-cycle watchdog ends it first.
  initial begin
    writeProtectPin = 1'b0;
    reset_n = 1'b0;
    void'($urandom(32'haec80774));
    repeat (20) @(posedge core_clk);
    #1 reset_n = 1'b1;
    `CHK("lockReset", 2'h0, lockBits)
    wr(WPC_TGT_EEPROM, 8'($urandom), 8'($urandom), 1'b0);
    wr(WPC_TGT_POT_VOL, 8'($urandom), 8'($urandom), 1'b0);
    wr(WPC_TGT_STATUS, 8'hff, 8'h06, 1'b0);
    rd(8'h00);
    wr(WPC_TGT_STATUS, 8'hff, 8'h02, 1'b1);
    rd(8'h02);
    wr(WPC_TGT_STATUS, 8'hff, 8'h0a, 1'b0);
    $display("test latches done");
    for (int lk = 1; lk < 4; lk++) begin
      wr(WPC_TGT_STATUS, 8'hff, 8'h06, 1'b1);
      rd({3'h0, 2'(lk - 1), 3'h6});
      // The lock write is its own frame, so a START opens it.
      u_wpc_master_model.ev(4'h1);
      wr(WPC_TGT_STATUS, 8'hff, {3'h0, 2'(lk), 3'h2}, 1'b1);
      u_wpc_master_model.ev(4'h2);
      `CHK("nvLaunch", 1'b1, nvSeen)
      repeat (60) @(posedge core_clk);
      `CHK("nvActive", 1'b1, deviceActive)
      repeat (50) @(posedge core_clk);
      `CHK("lockBits", 2'(lk), lockBits)
      rd({3'h0, 2'(lk), 3'h2});
      base = (lk == 1) ? 8'hc0 : (lk == 2) ? 8'h80 : 8'h00;
      wr(WPC_TGT_EEPROM, base, 8'($urandom), 1'b0);
      if (base != 8'h00) wr(WPC_TGT_EEPROM, base - 8'h1, 8'($urandom), 1'b1);
      wr(WPC_TGT_POT_NV, 8'($urandom), 8'($urandom), 1'b0);
    end
    // A lock write with a bad clock count or bit sequence must not launch at STOP.
    wr(WPC_TGT_STATUS, 8'hff, 8'h06, 1'b1);
    u_wpc_master_model.ev(4'h1);
    seqOk = 2'($urandom_range(2, 0));
    wr(WPC_TGT_STATUS, 8'hff, {3'h0, 2'($urandom), 3'h2}, 1'b1);
    seqOk = 2'h3;
    u_wpc_master_model.ev(4'h2);
    `CHK("badCounts", 1'b0, nvSeen)
    `CHK("lockKept", 2'h3, lockBits)
    $display("test locks done");
    writeProtectPin = 1'b1;
    repeat (8) @(posedge core_clk);
    wr(WPC_TGT_STATUS, 8'hff, 8'h02, 1'b0);
    wr(WPC_TGT_POT_VOL, 8'($urandom), 8'($urandom), 1'b0);
    writeProtectPin = 1'b0;
    u_wpc_master_model.ev(4'h9);
    `CHK("activeStart", 1'b1, deviceActive)
    repeat (9) u_wpc_master_model.ev(4'hc);
    repeat (2) @(posedge core_clk);
    `CHK("mismatchIdle", 1'b0, deviceActive)
    u_wpc_master_model.ev(4'h1);
    rd(8'h1a);
    `CHK("idleAfterRead", 1'b1, serialIdle)
    // Any address other than the status one gets no status answer.
    u_wpc_master_model.rdStatus(8'($urandom_range(254, 0)));
    `CHK("badAddr", 1'b0, statusValid)
    u_wpc_master_model.ev(4'h2);
    `CHK("noLaunch", 1'b0, nvSeen)
    repeat (40) @(posedge core_clk);
    `CHK("readActive", 1'b1, deviceActive)
    repeat (15) @(posedge core_clk);
    `CHK("readIdle", 1'b0, deviceActive)
    $display("test standby done");
    completeRun();
  end
endmodule
